// *** ccs_config_crc_status.sv ***
`timescale 1ns/1ps
// All inputs come from logic on clk, so none is synchronised here.
module ccs_config_crc_status (
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic       soft_reset,
    input  wire logic       output_cycle,
    input  wire logic [7:0] config_value,
    input  wire logic [7:0] temp_offset_value,
    input  wire logic       secondary_aux_bit,
    input  wire logic       lock_write,
    input  wire logic [7:0] lock_data,
    input  wire logic       primary_read,
    input  wire logic       secondary_read,
    input  wire logic       current_sample_read,
    input  wire logic       voltage1_sample_read,
    input  wire logic       voltage2_sample_read,
    output logic [15:0]     settings_checksum,
    output logic [7:0]      primary_state_register,
    output logic [7:0]      secondary_state_register,
    output logic            protection_enabled,
    output logic            checksum_busy
);

    // ==========================================================
    // Declarations
    logic                           protect_en_q;
    logic [ccs_pkg::RST_CNT_W-1:0]  rst_cnt_q;
    logic                           reset_on_q;
    logic                           init_req_q;
    logic                           run_init_q;
    logic [15:0]                    checksum_q;
    logic [2:0]                     read_mask_q;
    logic [2:0]                     read_mask_now;
    logic                           samples_valid_q;
    logic [7:0]                     primary_q;
    logic [7:0]                     secondary_q;

    logic                           lock_on_wr;
    logic                           lock_off_wr;
    logic                           crc_start;
    logic                           crc_busy;
    logic                           crc_done;
    logic [15:0]                    crc_result;
    logic [63:0]                    crc_din;

    logic                           chg_set;
    logic                           prot_set;
    logic                           unread_set;
    logic                           chg_flag;
    logic                           prot_flag;
    logic                           unread_flag;

    // ==========================================================
    // Lock register decode
    assign lock_on_wr  = lock_write && (lock_data == ccs_pkg::LOCK_ON_CODE);
    assign lock_off_wr = lock_write && (lock_data == ccs_pkg::LOCK_OFF_CODE);

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            protect_en_q <= 1'b0;
        end else if (soft_reset) begin
            protect_en_q <= 1'b0;
        end else if (lock_on_wr) begin
            protect_en_q <= 1'b1;
        end else if (lock_off_wr) begin
            protect_en_q <= 1'b0;
        end
    end

    // ==========================================================
    // Reset period timer
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rst_cnt_q <= ccs_pkg::RESET_CYCLES;
        end else if (soft_reset) begin
            rst_cnt_q <= ccs_pkg::RESET_CYCLES;
        end else if (rst_cnt_q != '0) begin
            rst_cnt_q <= rst_cnt_q - 1'b1;
        end
    end

    // Busy until the timer ends and the first checksum is in place
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            reset_on_q <= 1'b1;
        end else if (soft_reset) begin
            reset_on_q <= 1'b1;
        end else begin
            // [R10] clear at end of reset period
            if (rst_cnt_q == '0 && !init_req_q && !(crc_busy && run_init_q)) begin
                reset_on_q <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Checksum launch
    // [R01] array of config, offset and the two status bits
    always_comb begin
        crc_din = 64'h0;
        crc_din[ccs_pkg::IN_CFG_LSB +: 8]  = config_value;
        crc_din[ccs_pkg::IN_TOFS_LSB +: 8] = temp_offset_value;
        crc_din[ccs_pkg::IN_PROT_BIT]      = prot_flag;
        crc_din[ccs_pkg::IN_AUX_BIT]       = secondary_aux_bit;
    end

    // [R01] start once after reset and on each output cycle that finds the engine idle and no soft reset
    assign crc_start = !crc_busy && !soft_reset && (init_req_q || output_cycle);

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            init_req_q <= 1'b1;
            run_init_q <= 1'b0;
        end else if (soft_reset) begin
            init_req_q <= 1'b1;
            run_init_q <= 1'b0;
        end else if (crc_start) begin
            // [R06] first result from this part's offset
            init_req_q <= 1'b0;
            run_init_q <= init_req_q;
        end
    end

    ccs_crc_engine u_crc (
        .clk    (clk),
        .rstn   (rstn),
        .start  (crc_start),
        .din    (crc_din),
        .busy   (crc_busy),
        .done   (crc_done),
        .result (crc_result)
    );

    // ==========================================================
    // Checksum register
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            checksum_q <= ccs_pkg::CHECKSUM_RST;
        end else if (crc_done && !init_req_q) begin
            // [R01] store the new result, drop a run cut by a reset
            checksum_q <= crc_result;
        end
    end

    // [R16] compare with previous value before overwrite
    assign chg_set = crc_done && !run_init_q && !init_req_q && (crc_result != checksum_q);

    // ==========================================================
    // Status flags
    // [R07] checksum changed, cleared by primary read
    ccs_sticky_flag u_chg (
        .clk  (clk),
        .rstn (rstn),
        .wipe (soft_reset),
        .set  (chg_set),
        .clr  (primary_read),
        .flag (chg_flag)
    );

    // [R08] lock code sets protection flag
    // [R09] re-armed each output cycle while protected
    assign prot_set = lock_on_wr || (output_cycle && protect_en_q);

    ccs_sticky_flag u_prot (
        .clk  (clk),
        .rstn (rstn),
        .wipe (soft_reset),
        .set  (prot_set),
        .clr  (primary_read),
        .flag (prot_flag)
    );

    // ==========================================================
    // Sample read tracking
    assign read_mask_now = read_mask_q |
        {voltage2_sample_read, voltage1_sample_read, current_sample_read};

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            read_mask_q     <= 3'h0;
            samples_valid_q <= 1'b0;
        end else if (soft_reset) begin
            read_mask_q     <= 3'h0;
            samples_valid_q <= 1'b0;
        end else if (output_cycle) begin
            read_mask_q     <= 3'h0;
            samples_valid_q <= 1'b1;
        end else begin
            read_mask_q <= read_mask_now;
        end
    end

    // [R11] missing sample read at cycle boundary
    assign unread_set = output_cycle && samples_valid_q &&
        (read_mask_now != ccs_pkg::ALL_SAMPLES);

    // [R12] cleared by secondary read
    ccs_sticky_flag u_unread (
        .clk  (clk),
        .rstn (rstn),
        .wipe (soft_reset),
        .set  (unread_set),
        .clr  (secondary_read),
        .flag (unread_flag)
    );

    // ==========================================================
    // Status register images
    // [R13] images for single and burst reads
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            primary_q <= ccs_pkg::PRI_RESET;
        end else begin
            primary_q                            <= 8'h00;
            primary_q[ccs_pkg::PRI_RESET_ON_BIT] <= reset_on_q;
            primary_q[ccs_pkg::PRI_CRC_CHG_BIT]  <= chg_flag;
            primary_q[ccs_pkg::PRI_PROT_BIT]     <= prot_flag;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            secondary_q <= ccs_pkg::SEC_RESET;
        end else begin
            secondary_q                          <= 8'h00;
            secondary_q[ccs_pkg::SEC_UNREAD_BIT] <= unread_flag;
            secondary_q[ccs_pkg::SEC_AUX_BIT]    <= secondary_aux_bit;
        end
    end

    // ==========================================================
    // Outputs
    assign settings_checksum        = checksum_q;
    assign primary_state_register   = primary_q;
    assign secondary_state_register = secondary_q;
    assign protection_enabled       = protect_en_q;
    assign checksum_busy            = crc_busy;

endmodule

// *** ccs_pkg.sv ***
// Functional notes
// [R01] Each output cycle a 16-bit checksum is recomputed over config, temp offset, the protection flag and secondary status bit 7, and stored as the settings checksum.
// [R02] The checksum inputs form a 64-bit array that is fed one bit per step into an LFSR generator.
// [R03] Bytes enter least significant byte first, and each byte enters with its most significant bit first.
// [R04] All sixteen generator state bits start at one, with bit 0 as the LSB and bit 15 as the MSB.
// [R05] Each of 64 steps uses feedback = input XOR bit 15, bit 0 = feedback AND g0, higher bits = feedback AND gi XOR the lower bit; the final state is stored.
// [R06] The checksum value after power-on is computed from the part's own temperature offset, not a fixed constant.
// [R07] A change of the checksum value sets the checksum-changed flag at primary status bit 1, which clears when primary status is read.
// [R08] Writing lock code 0xCA sets the protection-active flag at primary status bit 2.
// [R09] The protection flag clears on a primary status read and is set again at the next output cycle while protection stays on.
// [R10] The reset-in-progress flag at primary status bit 0 stays set during power-up and any reset and clears when the reset period ends.
// [R11] If the current and both voltage samples are not all read within an output cycle, the samples-unread flag at secondary bit 3 sets.
// [R12] The samples-unread flag clears when the secondary status register is read.
// [R13] Both status registers are readable singly, and primary status is also offered to the burst read sequence.
// [R14] The generator polynomial is x^16 + x^12 + x^5 + 1, so coefficients 0, 5 and 12 are one.
// [R15] After any reset the master polls primary status until bit 0 reads zero before configuring the device.
// [R16] A checksum change is found by comparing each new result with the value held from the previous cycle.
// [R17] A flag-setting event in the same cycle as a status read wins, so the flag stays set.
package ccs_pkg;

    // ==========================================================
    // Timing
    localparam int          CLK_PERIOD_NS = 50;
    localparam int          RESET_TIME_NS = 100000;
    localparam int          RST_CNT_W     = 11;
    localparam logic [10:0] RESET_CYCLES  =
        11'((RESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // ==========================================================
    // Checksum generator
    localparam int          CRC_W         = 16;
    localparam int          CRC_IN_W      = 64;
    localparam logic [15:0] CRC_POLY      = 16'h1021;
    localparam logic [15:0] CRC_INIT      = 16'hffff;
    localparam logic [15:0] CHECKSUM_RST  = 16'h0000;
    localparam logic [5:0]  CRC_LAST_STEP = 6'h3f;

    // Input array layout
    localparam int          IN_CFG_LSB    = 0;
    localparam int          IN_TOFS_LSB   = 8;
    localparam int          IN_PROT_BIT   = 18;
    localparam int          IN_AUX_BIT    = 31;

    // ==========================================================
    // Status fields
    localparam int          PRI_RESET_ON_BIT = 0;
    localparam int          PRI_CRC_CHG_BIT  = 1;
    localparam int          PRI_PROT_BIT     = 2;
    localparam int          SEC_UNREAD_BIT   = 3;
    localparam int          SEC_AUX_BIT      = 7;
    localparam logic [7:0]  PRI_RESET        = 8'h01;
    localparam logic [7:0]  SEC_RESET        = 8'h00;

    // ==========================================================
    // Lock codes
    localparam logic [7:0]  LOCK_ON_CODE  = 8'hca;
    localparam logic [7:0]  LOCK_OFF_CODE = 8'h9c;

    localparam logic [2:0]  ALL_SAMPLES   = 3'h7;

    typedef enum logic [1:0] {
        CCS_IDLE  = 2'b01,
        CCS_SHIFT = 2'b10
    } ccs_crc_state_t;

endpackage

// *** ccs_sticky_flag.sv ***
`timescale 1ns/1ps
module ccs_sticky_flag (
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic wipe,
    input  wire logic set,
    input  wire logic clr,
    output logic      flag
);
    logic flag_q;
    logic flag_d;

    always_comb begin
        if (wipe) begin
            flag_d = 1'b0;
        end else begin
            // [R17] set beats clear
            flag_d = set | (flag_q & ~clr);
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            flag_q <= 1'b0;
        end else begin
            flag_q <= flag_d;
        end
    end

    assign flag = flag_q;
endmodule

// *** ccs_crc_engine.sv ***
`timescale 1ns/1ps
module ccs_crc_engine (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        start,
    input  wire logic [63:0] din,
    output logic             busy,
    output logic             done,
    output logic [15:0]      result
);
    ccs_pkg::ccs_crc_state_t state_q;
    logic [63:0]             data_q;
    logic [5:0]              step_q;
    logic [15:0]             lfsr_q;
    logic [15:0]             lfsr_d;
    logic                    in_bit;
    logic                    fb;
    logic                    done_q;
    logic [15:0]             result_q;

    // [R03] LSB byte first, MSB of each byte first
    assign in_bit = data_q[{step_q[5:3], ~step_q[2:0]}];
    // [R05] feedback and shift step
    assign fb     = in_bit ^ lfsr_q[15];
    // [R14] taps at bits 0, 5 and 12
    assign lfsr_d = {lfsr_q[14:0], 1'b0} ^ (fb ? ccs_pkg::CRC_POLY : 16'h0000);

    // ==========================================================
    // Sequencer
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= ccs_pkg::CCS_IDLE;
            step_q  <= 6'h00;
        end else begin
            case (state_q)
                ccs_pkg::CCS_IDLE: begin
                    if (start) begin
                        state_q <= ccs_pkg::CCS_SHIFT;
                        step_q  <= 6'h00;
                    end
                end
                ccs_pkg::CCS_SHIFT: begin
                    step_q <= step_q + 6'h01;
                    if (step_q == ccs_pkg::CRC_LAST_STEP) begin
                        state_q <= ccs_pkg::CCS_IDLE;
                    end
                end
                default: begin
                    state_q <= ccs_pkg::CCS_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // Shift register and result
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            data_q   <= 64'h0;
            lfsr_q   <= ccs_pkg::CRC_INIT;
            done_q   <= 1'b0;
            result_q <= ccs_pkg::CHECKSUM_RST;
        end else begin
            done_q <= 1'b0;
            if (state_q == ccs_pkg::CCS_IDLE && start) begin
                // [R02] snapshot of the 64-bit array
                data_q <= din;
                // [R04] preset all ones
                lfsr_q <= ccs_pkg::CRC_INIT;
            end else if (state_q == ccs_pkg::CCS_SHIFT) begin
                lfsr_q <= lfsr_d;
                if (step_q == ccs_pkg::CRC_LAST_STEP) begin
                    done_q   <= 1'b1;
                    result_q <= lfsr_d;
                end
            end
        end
    end

    assign busy   = (state_q == ccs_pkg::CCS_SHIFT);
    assign done   = done_q;
    assign result = result_q;
endmodule

// *** ccs_checker.sv ***
`timescale 1ns/1ps
// ==========================================
// Port checker
module ccs_checker (
    input wire logic        clk,
    input wire logic        rstn,
    input wire logic        soft_reset,
    input wire logic        output_cycle,
    input wire logic        lock_write,
    input wire logic [7:0]  lock_data,
    input wire logic        primary_read,
    input wire logic        secondary_read,
    input wire logic        current_sample_read,
    input wire logic        voltage1_sample_read,
    input wire logic        voltage2_sample_read,
    input wire logic [15:0] settings_checksum,
    input wire logic [7:0]  primary_state_register,
    input wire logic [7:0]  secondary_state_register,
    input wire logic        protection_enabled,
    input wire logic        checksum_busy
);
    logic [6:0]  bc_q;
    logic [11:0] rc_q;
    logic [2:0]  rd_q;
    logic        seen_q;
    logic [2:0]  rd_now;

    assign rd_now = {voltage2_sample_read, voltage1_sample_read, current_sample_read};

    // ==========================================
    // Helper counters
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) bc_q <= 7'h0;
        else bc_q <= checksum_busy ? bc_q + 7'h1 : 7'h0;
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) rc_q <= 12'h0;
        else if (soft_reset) rc_q <= 12'h0;
        else if (rc_q != 12'hfff) rc_q <= rc_q + 12'h1;
    end
    // Samples read since the last boundary
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rd_q   <= 3'h0;
            seen_q <= 1'b0;
        end else begin
            rd_q   <= (soft_reset || output_cycle) ? 3'h0 : (rd_q | rd_now);
            seen_q <= !soft_reset && (seen_q || output_cycle);
        end
    end

    // ==========================================
    // Properties
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);

    sequence s_lock_on;
        lock_write && lock_data == 8'hca && !soft_reset;
    endsequence
    sequence s_prot_seen;
        protection_enabled ##1 primary_state_register[2];
    endsequence

    property p_shift_len;
        $fell(checksum_busy) |-> bc_q == 7'd64;
    endproperty
    a_shift_len: assert property (p_shift_len) else $error("shift count");
    property p_ck_load;
        $changed(settings_checksum) |-> $past(checksum_busy, 2) && !$past(checksum_busy);
    endproperty
    a_ck_load: assert property (p_ck_load) else $error("checksum load");
    property p_chg_set;
        ($changed(settings_checksum) && !primary_state_register[0] && !$past(soft_reset))
            |=> primary_state_register[1];
    endproperty
    a_chg_set: assert property (p_chg_set) else $error("change flag");
    property p_chg_cause;
        $rose(primary_state_register[1])
            |-> $past(settings_checksum) != $past(settings_checksum, 2);
    endproperty
    a_chg_cause: assert property (p_chg_cause) else $error("change cause");
    property p_prot_lock;
        s_lock_on |=> s_prot_seen;
    endproperty
    a_prot_lock: assert property (p_prot_lock) else $error("lock on");
    property p_prot_clr;
        (primary_read && !lock_write && !output_cycle) |-> ##2 !primary_state_register[2];
    endproperty
    a_prot_clr: assert property (p_prot_clr) else $error("prot clear");
    property p_prot_again;
        (output_cycle && protection_enabled && !lock_write && !soft_reset)
            |-> ##2 primary_state_register[2];
    endproperty
    a_prot_again: assert property (p_prot_again) else $error("prot again");
    property p_unread_set;
        (output_cycle && seen_q && (rd_q | rd_now) != 3'h7 && !soft_reset)
            |-> ##2 secondary_state_register[3];
    endproperty
    a_unread_set: assert property (p_unread_set) else $error("unread set");
    property p_unread_clr;
        (secondary_read && !output_cycle) |-> ##2 !secondary_state_register[3];
    endproperty
    a_unread_clr: assert property (p_unread_clr) else $error("unread clear");
    property p_rst_on;
        (rc_q > 12'd2 && rc_q < 12'd1990) |-> primary_state_register[0];
    endproperty
    a_rst_on: assert property (p_rst_on) else $error("reset flag early");
    property p_rst_off;
        (rc_q > 12'd2010) |-> !primary_state_register[0];
    endproperty
    a_rst_off: assert property (p_rst_off) else $error("reset flag late");
endmodule

// *** ccs_host_model.sv ***
`timescale 1ns/1ps
// ==========================================
// Serial master stand-in
module ccs_host_model (
    input  wire logic       clk,
    input  wire logic [7:0] pri,
    input  wire logic [7:0] sec,
    output logic            primary_read,
    output logic            secondary_read,
    output logic            current_sample_read,
    output logic            voltage1_sample_read,
    output logic            voltage2_sample_read
);
    initial begin
        {primary_read, secondary_read, current_sample_read} = 3'h0;
        {voltage1_sample_read, voltage2_sample_read} = 2'h0;
    end
    task automatic rd(input logic s, output logic [7:0] v);
        @(posedge clk);
        #1;
        primary_read   = !s;
        secondary_read = s;
        @(posedge clk);
        v = s ? sec : pri;
        #1;
        primary_read   = 1'b0;
        secondary_read = 1'b0;
    endtask
    task automatic samp(input logic [2:0] m);
        @(posedge clk);
        #1;
        {voltage2_sample_read, voltage1_sample_read, current_sample_read} = m;
        @(posedge clk);
        #1;
        {voltage2_sample_read, voltage1_sample_read, current_sample_read} = 3'h0;
    endtask
    task automatic poll(output logic [7:0] v);
        v = 8'h01;
        for (int n = 0; n < 2000 && v[0] !== 1'b0; n++) rd(1'b0, v);
    endtask
endmodule

// *** testbench.sv ***
`timescale 1ns/1ps
// ==========================================
// Bench top
module testbench;
    logic        clk, rstn, soft_reset, output_cycle, secondary_aux_bit, lock_write;
    logic        primary_read, secondary_read, checksum_busy, protection_enabled;
    logic        current_sample_read, voltage1_sample_read, voltage2_sample_read;
    logic [7:0]  config_value, temp_offset_value, lock_data, v, e;
    logic [7:0]  primary_state_register, secondary_state_register;
    logic [15:0] settings_checksum, prev, e0;
    logic [2:0]  acc, m;
    logic        chg_m, prot_m, un_m, en_m, first;
    int          bad_count, cmp_count, cyc, seed, t0;

    ccs_config_crc_status dut_u (.*);
    ccs_host_model host_u (.clk, .pri(primary_state_register), .sec(secondary_state_register),
        .primary_read, .secondary_read, .current_sample_read, .voltage1_sample_read,
        .voltage2_sample_read);

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string n);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", n, exp, got);
        end
    endtask
    task automatic stop_test();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Bit-serial reference generator
    function automatic logic [15:0] crc(input logic [7:0] c, t, input logic p, a);
        logic [63:0] d;
        logic [15:0] s;
        logic        f;
        d = {32'h0, a, 12'h0, p, 2'h0, t, c};
        s = 16'hffff;
        for (int k = 0; k < 64; k++) begin
            f = d[8 * (k / 8) + 7 - k % 8] ^ s[15];
            s = {s[14:0], 1'b0} ^ (f ? 16'h1021 : 16'h0000);
        end
        return s;
    endfunction
    task automatic lock(input logic [7:0] d);
        @(posedge clk);
        #1;
        lock_write = 1'b1;
        lock_data  = d;
        @(posedge clk);
        #1;
        lock_write = 1'b0;
        if (d == 8'hca) {en_m, prot_m} = 2'b11;
        if (d == 8'h9c) en_m = 1'b0;
    endtask
    task automatic pulse_oc(input logic r);
        @(posedge clk);
        #1;
        if (r) soft_reset = 1'b1;
        else output_cycle = 1'b1;
        @(posedge clk);
        #1;
        {soft_reset, output_cycle} = 2'b00;
    endtask
    task automatic wait_ready();
        t0 = cyc;
        host_u.poll(v);
        chk(32'(cyc - t0 >= 2000 && cyc - t0 <= 2012), 32'h1, "reset_len");
    endtask
    task automatic ocyc();
        e0 = crc(config_value, temp_offset_value, prot_m, secondary_aux_bit);
        pulse_oc(1'b0);
        chk(checksum_busy, 1'b1, "busy");
        if (!first && acc != 3'h7) un_m = 1'b1;
        if (en_m) prot_m = 1'b1;
        {first, acc} = 4'h0;
        repeat (65) @(posedge clk);
        #1;
        chk(checksum_busy, 1'b0, "idle");
        chk(settings_checksum, e0, "checksum");
        if (e0 != prev) chg_m = 1'b1;
        prev = e0;
    endtask

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            stop_test();
        end
    end

    initial begin
        seed = 98429;
        {rstn, soft_reset, output_cycle, lock_write, lock_data} = '0;
        {config_value, temp_offset_value} = 16'($random(seed));
        secondary_aux_bit = 1'b1;
        {chg_m, prot_m, un_m, en_m, acc, prev} = '0;
        first = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        chk(settings_checksum, 16'h0000, "rst_checksum");
        chk(primary_state_register, 8'h01, "rst_primary");
        chk(secondary_state_register, 8'h00, "rst_secondary");
        chk(protection_enabled, 1'b0, "rst_prot");
        rstn = 1'b1;
        wait_ready();
        e0 = crc(config_value, temp_offset_value, 1'b0, secondary_aux_bit);
        chk(settings_checksum, e0, "init_checksum");
        chk(v, 8'h00, "init_status");
        prev = e0;
        for (int i = 0; i < 8; i++) begin
            if (i != 4) {config_value, temp_offset_value, secondary_aux_bit} = 17'($random(seed));
            m = (i % 3 == 1) ? 3'h7 : (i == 5 ? 3'h5 : 3'($random(seed)));
            host_u.samp(m);
            acc = acc | m;
            if (i == 2) begin
                e = {5'h0, prot_m, chg_m, 1'b0};
                fork
                    lock(8'hca);
                    host_u.rd(1'b0, v);
                join
                chk(v, e, "read_at_lock");
                repeat (2) @(posedge clk);
                host_u.rd(1'b0, v);
                chk(v, 8'h04, "set_wins");
                {chg_m, prot_m} = 2'b00;
            end
            if (i == 6) lock(8'h9c);
            ocyc();
            host_u.rd(1'b0, v);
            chk(v, {5'h0, prot_m, chg_m, 1'b0}, "primary");
            {chg_m, prot_m} = 2'b00;
            host_u.rd(1'b1, v);
            chk(v, {secondary_aux_bit, 3'h0, un_m, 3'h0}, "secondary");
            un_m = 1'b0;
            chk(protection_enabled, en_m, "prot_level");
            $display("test %0d done", i);
        end
        lock(8'hca);
        pulse_oc(1'b1);
        wait_ready();
        chk(v, 8'h00, "soft_status");
        chk(protection_enabled, 1'b0, "soft_prot");
        e0 = crc(config_value, temp_offset_value, 1'b0, secondary_aux_bit);
        chk(settings_checksum, e0, "soft_checksum");
        $display("test soft reset done");
        stop_test();
    end
endmodule

bind ccs_config_crc_status ccs_checker chk_u (.*);
